// *** hdl/add_decode_and_vectors.sv ***
// Purpose: Decode both formats, execute the add families, steer the PC
// Assumes: Register file has asynchronous read; instructions arrive on i_mclk
// Notes:   Decode then execute; result and carry land at the same edge
`timescale 1ns/1ps
`default_nettype none
module add_decode_and_vectors (
    input  wire logic        i_mclk,              // Core clock, 100 MHz
    input  wire logic        i_rst_b,             // Async reset, active low
    input  wire logic [31:0] i_instr,             // Fetched instruction word
    input  wire logic        i_instr_valid,       // Word valid for o_pc
    input  wire logic        i_exception,         // Exception request, one cycle
    input  wire logic        i_interrupt,         // Interrupt request, one cycle
    input  wire logic [31:0] i_src_a_data,        // Read data, first source
    input  wire logic [31:0] i_src_b_data,        // Read data, second source
    output logic      [31:0] o_pc,                // Fetch address
    output logic      [4:0]  o_rf_rd_addr_a,      // First source address
    output logic      [4:0]  o_rf_rd_addr_b,      // Second source address
    output logic             o_rf_wr_en,          // Write strobe, one cycle
    output logic      [4:0]  o_rf_wr_addr,        // Destination address
    output logic      [31:0] o_rf_wr_data,        // Destination data
    output logic             o_status_carry_flag  // Status carry flag
);
    import add_decode_pkg::*;

    // ==========================================================
    // Decode helpers
    // ==========================================================
    // Opcode field of a word
    function automatic logic [5:0] opc_of(input logic [31:0] w);
        opc_of = w[OPC_LSB +: OPC_W];
    endfunction : opc_of

    // Family match ignoring the carry and keep bits
    function automatic logic in_family(input logic [5:0] opc, input logic [5:0] base);
        in_family = ((opc & ~OPC_VAR_MASK) == base);
    endfunction : in_family

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta_r;
    logic rst_sync_b_r;

    // Assert at once, release two edges later
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta_r   <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end
        else
        begin
            rst_meta_r   <= 1'b1;
            rst_sync_b_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // State
    // ==========================================================
    logic        dec_valid_r,  dec_valid_nxt;
    logic [31:0] dec_instr_r,  dec_instr_nxt;
    logic [31:0] pc_r,         pc_nxt;
    logic [4:0]  rd_a_r,       rd_a_nxt;
    logic [4:0]  rd_b_r,       rd_b_nxt;
    logic        wr_en_r,      wr_en_nxt;
    logic [4:0]  wr_addr_r,    wr_addr_nxt;
    logic [31:0] wr_data_r,    wr_data_nxt;
    logic        carry_r,      carry_nxt;
    logic [15:0] imm_hi_r,     imm_hi_nxt;
    logic        imm_pend_r,   imm_pend_nxt;

    // ==========================================================
    // Decode of the word in the execute slot
    // ==========================================================
    logic [5:0]  exe_opc;
    logic [4:0]  exe_rd;
    logic [15:0] exe_imm16;
    logic        exe_is_rr;
    logic        exe_is_ri;
    logic        exe_is_prefix;
    logic [31:0] exe_imm32;

    add_exec_if exec_bus ();

    add_unit u_add_unit (
        .port_x (exec_bus)
    );

    // Field split and operand choice
    always_comb
    begin
        exe_opc       = opc_of(dec_instr_r);
        exe_rd        = dec_instr_r[RD_LSB +: REG_AW];
        exe_imm16     = dec_instr_r[IMM_LSB +: IMM_W];
        exe_is_rr     = in_family(exe_opc, OPC_ADD_BASE);
        exe_is_ri     = in_family(exe_opc, OPC_ADDI_BASE);
        exe_is_prefix = (exe_opc == OPC_IMM_PREFIX);
        // Prefix supplies the upper half, else sign extension
        if (imm_pend_r)
            exe_imm32 = {imm_hi_r, exe_imm16};
        else
            exe_imm32 = {{IMM_W{exe_imm16[15]}}, exe_imm16};
        exec_bus.op_a     = i_src_a_data;
        exec_bus.op_b     = exe_is_ri ? exe_imm32 : i_src_b_data;
        exec_bus.carry_in = exe_opc[OPC_C_BIT] & carry_r;
    end

    // ==========================================================
    // Fetch, decode and execute next values
    // ==========================================================
    // Redirect squashes the word in decode; a late prefix must not leak
    // Exception outranks interrupt when both arrive together
    always_comb
    begin
        dec_valid_nxt = 1'b0;
        dec_instr_nxt = dec_instr_r;
        pc_nxt        = pc_r;
        rd_a_nxt      = rd_a_r;
        rd_b_nxt      = rd_b_r;
        wr_en_nxt     = 1'b0;
        wr_addr_nxt   = wr_addr_r;
        wr_data_nxt   = wr_data_r;
        carry_nxt     = carry_r;
        imm_hi_nxt    = imm_hi_r;
        imm_pend_nxt  = imm_pend_r;

        if (i_exception)
        begin
            pc_nxt       = VEC_EXC;
            imm_pend_nxt = 1'b0;
        end
        else if (i_interrupt)
        begin
            pc_nxt       = VEC_INT;
            imm_pend_nxt = 1'b0;
        end
        else
        begin
            // Accept the fetched word and start its source reads
            if (i_instr_valid)
            begin
                dec_valid_nxt = 1'b1;
                dec_instr_nxt = i_instr;
                rd_a_nxt      = i_instr[RA_LSB +: REG_AW];
                rd_b_nxt      = i_instr[RB_LSB +: REG_AW];
                pc_nxt        = pc_r + PC_STEP;
            end
            // Execute whatever sits in decode this cycle
            if (dec_valid_r)
            begin
                if (exe_is_rr || exe_is_ri)
                begin
                    wr_en_nxt   = 1'b1;
                    wr_addr_nxt = exe_rd;
                    wr_data_nxt = exec_bus.sum;
                    if (!exe_opc[OPC_K_BIT])
                        carry_nxt = exec_bus.carry_out;
                    else
                        carry_nxt = carry_r;
                end
                // A prefix arms only the very next executed word
                if (exe_is_prefix)
                begin
                    imm_hi_nxt   = exe_imm16;
                    imm_pend_nxt = 1'b1;
                end
                else
                begin
                    imm_pend_nxt = 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge i_mclk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
        begin
            dec_valid_r <= 1'b0;
            dec_instr_r <= WORD_RST;
            pc_r        <= VEC_RESET;
            rd_a_r      <= REG_RST;
            rd_b_r      <= REG_RST;
            wr_en_r     <= 1'b0;
            wr_addr_r   <= REG_RST;
            wr_data_r   <= WORD_RST;
            carry_r     <= 1'b0;
            imm_hi_r    <= HALF_RST;
            imm_pend_r  <= 1'b0;
        end
        else
        begin
            dec_valid_r <= dec_valid_nxt;
            dec_instr_r <= dec_instr_nxt;
            pc_r        <= pc_nxt;
            rd_a_r      <= rd_a_nxt;
            rd_b_r      <= rd_b_nxt;
            wr_en_r     <= wr_en_nxt;
            wr_addr_r   <= wr_addr_nxt;
            wr_data_r   <= wr_data_nxt;
            carry_r     <= carry_nxt;
            imm_hi_r    <= imm_hi_nxt;
            imm_pend_r  <= imm_pend_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    // ==========================================================
    assign o_pc                = pc_r;
    assign o_rf_rd_addr_a      = rd_a_r;
    assign o_rf_rd_addr_b      = rd_b_r;
    assign o_rf_wr_en          = wr_en_r;
    assign o_rf_wr_addr        = wr_addr_r;
    assign o_rf_wr_data        = wr_data_r;
    assign o_status_carry_flag = carry_r;

endmodule : add_decode_and_vectors
`default_nettype wire

// *** hdl/add_decode_pkg.sv ***
// Purpose: Shared constants for the add decoder and vector selection
// Assumes: Bit numbering is LSB = 0; instruction bit 0 maps to instr[0]
// Notes:   Opcode codes are held here once; families match under a variant mask
package add_decode_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int unsigned XLEN      = 32;
    localparam int unsigned REG_AW    = 5;
    localparam int unsigned OPC_W     = 6;
    localparam int unsigned IMM_W     = 16;

    // ==========================================================
    // Program counter targets
    // ==========================================================
    localparam logic [31:0] VEC_RESET = 32'h0000_0000;
    localparam logic [31:0] VEC_EXC   = 32'h0000_0008;
    localparam logic [31:0] VEC_INT   = 32'h0000_0010;
    localparam logic [31:0] PC_STEP   = 32'h0000_0004;

    // ==========================================================
    // Field positions (LSB index of each field)
    // ==========================================================
    localparam int unsigned OPC_LSB   = 26;
    localparam int unsigned RD_LSB    = 21;
    localparam int unsigned RA_LSB    = 16;
    localparam int unsigned RB_LSB    = 11;
    localparam int unsigned IMM_LSB   = 0;
    localparam int unsigned OPC_K_BIT = 2;  // Keep-carry bit inside the opcode
    localparam int unsigned OPC_C_BIT = 1;  // Carry-in bit inside the opcode

    // ==========================================================
    // Opcodes
    // ==========================================================
    localparam logic [5:0] OPC_ADD_BASE   = 6'h00;
    localparam logic [5:0] OPC_ADDI_BASE  = 6'h08;
    localparam logic [5:0] OPC_IMM_PREFIX = 6'h2C;
    localparam logic [5:0] OPC_VAR_MASK   = 6'h06;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;
    localparam logic [15:0] HALF_RST  = 16'h0000;
    localparam logic [4:0]  REG_RST   = 5'h00;

endpackage : add_decode_pkg

// *** hdl/add_exec_if.sv ***
// Purpose: Operand and result bundle between decoder and adder
// Assumes: Purely combinational traffic inside one clock domain
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
interface add_exec_if;
    logic [31:0] op_a;       // First operand
    logic [31:0] op_b;       // Second operand
    logic        carry_in;   // Carry into bit 0
    logic [31:0] sum;        // Sum result
    logic        carry_out;  // Carry out of bit 31

    modport decoder (output op_a, output op_b, output carry_in, input sum, input carry_out);
    modport adder   (input op_a, input op_b, input carry_in, output sum, output carry_out);
endinterface : add_exec_if
`default_nettype wire

// *** hdl/add_unit.sv ***
// Purpose: 32-bit adder with carry in and carry out
// Assumes: Operands settle within the cycle
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module add_unit (
    add_exec_if.adder       port_x    // Operands in, sum out
);
    import add_decode_pkg::*;

    logic [32:0] wide_sum;

    // ==========================================================
    // Adder
    // ==========================================================
    // Extra bit captures the carry out of bit 31
    always_comb
    begin
        wide_sum = {1'b0, port_x.op_a} + {1'b0, port_x.op_b} + {32'h0000_0000, port_x.carry_in};
    end

    assign port_x.sum       = wide_sum[31:0];
    assign port_x.carry_out = wide_sum[32];
endmodule : add_unit
`default_nettype wire

// *** verification/add_decode_checker.sv ***
// Purpose: Port-level checks for add_decode_and_vectors
// Assumes: Bound onto the top module, one clock domain
// Notes:   Sees ports only; no internal state
`timescale 1ns/1ps
`default_nettype none
module add_decode_checker
    import add_decode_pkg::*;
(
    input wire logic        i_mclk,              // Clock
    input wire logic        i_rst_b,             // Reset, active low
    input wire logic [31:0] i_instr,             // Word
    input wire logic        i_instr_valid,       // Word valid
    input wire logic        i_exception,         // Exception
    input wire logic        i_interrupt,         // Interrupt
    input wire logic [31:0] i_src_a_data,        // First read data
    input wire logic [31:0] i_src_b_data,        // Second read data
    input wire logic [31:0] o_pc,                // Fetch address
    input wire logic [4:0]  o_rf_rd_addr_a,      // First source
    input wire logic [4:0]  o_rf_rd_addr_b,      // Second source
    input wire logic        o_rf_wr_en,          // Write strobe
    input wire logic [4:0]  o_rf_wr_addr,        // Destination
    input wire logic [31:0] o_rf_wr_data,        // Result
    input wire logic        o_status_carry_flag  // Carry flag
);
    // ==========================================================
    // Helpers
    // ==========================================================
    // Quiet means no redirect, so the stage is not squashed
    logic take;
    logic quiet;
    logic is_add;
    assign quiet  = !i_exception && !i_interrupt;
    assign take   = i_instr_valid && quiet;
    assign is_add = ((i_instr[31:26] & ~OPC_VAR_MASK) == OPC_ADD_BASE)
                 || ((i_instr[31:26] & ~OPC_VAR_MASK) == OPC_ADDI_BASE);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    // ==========================================================
    // Properties
    // ==========================================================
    reset_pc_a: assert property ($rose(i_rst_b) |-> o_pc == VEC_RESET)
        else $error("pc not zero after reset");
    exc_vec_a: assert property (i_exception |=> o_pc == VEC_EXC)
        else $error("exception vector wrong");
    int_vec_a: assert property (i_interrupt && !i_exception |=> o_pc == VEC_INT)
        else $error("interrupt vector wrong");
    pc_step_a: assert property (take |=> o_pc == $past(o_pc) + PC_STEP)
        else $error("pc did not step");
    src_field_a: assert property (take |=> o_rf_rd_addr_a == $past(i_instr[20:16])
        && o_rf_rd_addr_b == $past(i_instr[15:11])) else $error("source fields wrong");
    write_lat_a: assert property (take && is_add ##1 quiet |=> o_rf_wr_en
        && o_rf_wr_addr == $past(i_instr[25:21], 2)) else $error("add write late or misplaced");
    reg_sum_a: assert property (take && i_instr[31:26] == OPC_ADD_BASE ##1 quiet |=>
        {o_status_carry_flag, o_rf_wr_data} == {1'b0, $past(i_src_a_data)} + {1'b0, $past(i_src_b_data)})
        else $error("plain add sum or carry wrong");
    keep_carry_a: assert property (take && is_add && i_instr[28] ##1 quiet |=> $stable(o_status_carry_flag))
        else $error("keep variant changed carry");
    squash_a: assert property (take && is_add ##1 !quiet |=> !o_rf_wr_en)
        else $error("squashed add wrote");
    non_add_a: assert property (take && !is_add ##1 quiet |=> !o_rf_wr_en)
        else $error("non add wrote");
endmodule : add_decode_checker

bind add_decode_and_vectors add_decode_checker u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_instr(i_instr),
    .i_instr_valid(i_instr_valid), .i_exception(i_exception), .i_interrupt(i_interrupt),
    .i_src_a_data(i_src_a_data), .i_src_b_data(i_src_b_data), .o_pc(o_pc), .o_rf_rd_addr_a(o_rf_rd_addr_a),
    .o_rf_rd_addr_b(o_rf_rd_addr_b), .o_rf_wr_en(o_rf_wr_en), .o_rf_wr_addr(o_rf_wr_addr),
    .o_rf_wr_data(o_rf_wr_data), .o_status_carry_flag(o_status_carry_flag));
`default_nettype wire

// *** verification/rf_model.sv ***
// Purpose: Register file seen by the decoder, asynchronous read
// Assumes: Fixed contents; writes are ignored
// Notes:   Low registers carry ones on top so sums overflow
`timescale 1ns/1ps
`default_nettype none
module rf_model (
    input  wire logic [4:0]  i_addr_a,  // First read address
    input  wire logic [4:0]  i_addr_b,  // Second read address
    output logic      [31:0] o_data_a,  // First read data
    output logic      [31:0] o_data_b   // Second read data
);
    // Combinational read, valid in the cycle the address shows
    assign o_data_a = i_addr_a[4] ? {27'h0, i_addr_a} : {28'hFFFFFFF, i_addr_a[3:0]};
    assign o_data_b = i_addr_b[4] ? {27'h0, i_addr_b} : {28'hFFFFFFF, i_addr_b[3:0]};
endmodule : rf_model
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: Self-checking bench for add_decode_and_vectors
// Assumes: Inputs change on the falling edge
// Notes:   Carry flag is modelled here from sums
`timescale 1ns/1ps
`default_nettype none
module tb;
    import add_decode_pkg::*;
    logic i_mclk, i_rst_b, i_instr_valid, i_exception, i_interrupt, o_rf_wr_en, o_status_carry_flag;
    logic [31:0] i_instr, i_src_a_data, i_src_b_data, o_pc, o_rf_wr_data;
    logic [4:0]  o_rf_rd_addr_a, o_rf_rd_addr_b, o_rf_wr_addr;
    logic        carry_m;
    int          fails, samples_checked;

    // ==========================================================
    // Clock, design, register file
    // ==========================================================
    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    add_decode_and_vectors DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_instr(i_instr),
        .i_instr_valid(i_instr_valid), .i_exception(i_exception), .i_interrupt(i_interrupt),
        .i_src_a_data(i_src_a_data), .i_src_b_data(i_src_b_data), .o_pc(o_pc), .o_rf_rd_addr_a(o_rf_rd_addr_a),
        .o_rf_rd_addr_b(o_rf_rd_addr_b), .o_rf_wr_en(o_rf_wr_en), .o_rf_wr_addr(o_rf_wr_addr),
        .o_rf_wr_data(o_rf_wr_data), .o_status_carry_flag(o_status_carry_flag));
    rf_model u_rf (.i_addr_a(o_rf_rd_addr_a), .i_addr_b(o_rf_rd_addr_b), .o_data_a(i_src_a_data),
        .o_data_b(i_src_b_data));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    // Same contents as the register file model
    function automatic logic [31:0] rv(input logic [4:0] n);
        rv = n[4] ? {27'h0, n} : {28'hFFFFFFF, n[3:0]};
    endfunction : rv
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : chk
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // One word taken, then the write two edges later
    task automatic exec_word(input logic [31:0] w, input logic [31:0] ed, input logic ec);
        @(negedge i_mclk);
        i_instr = w;
        i_instr_valid = 1'b1;
        @(negedge i_mclk);
        i_instr_valid = 1'b0;
        @(negedge i_mclk);
        chk({31'h0, o_rf_wr_en}, 32'h1);
        chk({27'h0, o_rf_wr_addr}, {27'h0, w[25:21]});
        chk(o_rf_wr_data, ed);
        chk({31'h0, o_status_carry_flag}, {31'h0, ec});
    endtask : exec_word
    task automatic do_reset();
        @(negedge i_mclk);
        i_rst_b = 1'b0;
        @(negedge i_mclk);
        chk(o_pc, VEC_RESET);
        i_rst_b = 1'b1;
        carry_m = 1'b0;
        repeat (2) @(negedge i_mclk);
    endtask : do_reset

    // ==========================================================
    // Scenarios
    // ==========================================================
    // All four variants of both formats, one word every third cycle
    task automatic t_add_family();
        logic [5:0]  opc;
        logic [4:0]  ra;
        logic [31:0] b, w;
        logic [32:0] s;
        for (int f = 0; f < 2; f++)
            for (int v = 0; v < 4; v++)
            begin
                opc = (f != 0 ? OPC_ADDI_BASE : OPC_ADD_BASE) | 6'(v << 1);
                ra  = v[0] ? 5'd17 : 5'd1;
                w   = {opc, 5'(3 + v), ra, 5'd18, 11'h0};
                if (f != 0)
                    w[15:0] = 16'hFFF0;
                b   = (f != 0) ? 32'hFFFF_FFF0 : rv(5'd18);
                s   = {1'b0, rv(ra)} + {1'b0, b} + {32'h0, v[0] & carry_m};
                if (!v[1])
                    carry_m = s[32];
                exec_word(w, s[31:0], carry_m);
            end
    endtask : t_add_family
    // Prefix word supplies the upper half; sign bit of low half ignored
    task automatic t_prefix();
        @(negedge i_mclk);
        i_instr = {OPC_IMM_PREFIX, 10'h0, 16'h1234};
        i_instr_valid = 1'b1;
        carry_m = 1'b0;
        exec_word({OPC_ADDI_BASE, 5'd5, 5'd17, 16'h8001}, 32'h1234_8012, 1'b0);
    endtask : t_prefix
    // Exception squashes the add in execute; interrupt follows
    task automatic t_redirect();
        @(negedge i_mclk);
        i_instr = {OPC_ADD_BASE, 5'd7, 5'd1, 5'd18, 11'h0};
        i_instr_valid = 1'b1;
        @(negedge i_mclk);
        i_instr_valid = 1'b0;
        i_exception = 1'b1;
        @(negedge i_mclk);
        i_exception = 1'b0;
        chk(o_pc, VEC_EXC);
        chk({31'h0, o_rf_wr_en}, 32'h0);
        i_interrupt = 1'b1;
        @(negedge i_mclk);
        i_interrupt = 1'b0;
        chk(o_pc, VEC_INT);
    endtask : t_redirect

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        i_rst_b = 1'b0;
        i_instr = 32'h0;
        i_instr_valid = 1'b0;
        i_exception = 1'b0;
        i_interrupt = 1'b0;
        fails = 0;
        samples_checked = 0;
        carry_m = 1'b0;
        repeat (10) @(negedge i_mclk);
        do_reset();
        t_add_family();
        t_prefix();
        t_redirect();
        do_reset();
        t_add_family();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
